// ### hdl/spi_target_pkg.sv
// Constants for the sixteen-bit serial target port.
// Operation
// - Each frame carries one sixteen-bit word on serial data in, host clocked.
// - Frame starts when select_n falls; clock and data ignored while it is high.
// - The received word is acted on only after select_n rises.
// - Serial data out is released to high impedance when select_n rises.
// - Serial data in is captured on every falling serial clock edge.
// - Output shift register advances after every rising serial clock edge but the eighth, which loads the response byte.
// - No daisy chaining; input bits never reach the output.
// - Bits 6..0 address, bit 7 write or clear, bits 15..8 data.
// - Words without 0 or 16 clocks are dropped; error shows first next frame.
// - In restart mode received frames are never interpreted.
// - A written control register answers its old value in that frame.
package spi_target_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W      = 5;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
    // Count saturates one past a full frame so long frames stay flagged.
    localparam logic [CNT_W-1:0] CNT_OVER = 5'h11;
    localparam logic [CNT_W-1:0] CNT_STEP = 5'h01;
    // Falling edges seen before the last address bit arrives.
    localparam logic [CNT_W-1:0] CNT_ADDR = 5'h06;
    // Rising edges seen before the first response data bit goes out.
    localparam logic [CNT_W-1:0] CNT_RSP  = 5'h07;
    localparam int ADDR_LSB   = 0;
    localparam int ADDR_W     = 7;
    localparam int WR_BIT     = 7;
    localparam int DATA_LSB   = 8;
    localparam int DATA_W     = 8;
endpackage

// ### hdl/spi_target_port.sv
// Sixteen-bit serial target port with oversampled link pins.
`timescale 1ns/100ps
module spi_target_port
    import spi_target_pkg::*;
(
    input  wire logic              i_sys_clk,     // System clock, 100 MHz.
    input  wire logic              i_nrst,        // Asynchronous reset, active low.
    input  wire logic              i_sclk,        // Serial clock from host.
    input  wire logic              i_select_n,    // Frame select, active low.
    input  wire logic              i_sdi,         // Serial data in.
    output logic                   o_sdo,         // Serial data out value.
    output logic                   o_sdo_oe,      // High while driving serial data out.
    input  wire logic              i_restart,     // Device in restart mode (reset_output_pin low).
    input  wire logic [DATA_W-1:0] i_rsp_data,    // Response byte for the addressed register.
    output logic [ADDR_W-1:0]      o_rsp_addr,    // Address of the frame in progress.
    output logic                   o_cmd_valid,   // One-cycle pulse: accepted word.
    output logic [ADDR_W-1:0]      o_cmd_addr,    // Accepted register address.
    output logic                   o_cmd_write,   // Accepted write or read-and-clear bit.
    output logic [DATA_W-1:0]      o_cmd_data     // Accepted data byte.
);
    typedef struct packed {
        logic [1:0]            sclk_s;
        logic [1:0]            csn_s;
        logic [1:0]            sdi_s;
        logic                  sclk_d;
        logic                  csn_d;
        logic [FRAME_BITS-1:0] rx;
        logic [FRAME_BITS-1:0] tx;
        logic [CNT_W-1:0]      cnt;
        logic                  err;
        logic                  rst_seen;
        logic                  sdo;
        logic                  oe;
        logic [ADDR_W-1:0]     rsp_addr;
        logic                  valid;
        logic [ADDR_W-1:0]     addr;
        logic                  wr;
        logic [DATA_W-1:0]     data;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic sclk;
    logic select_n;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_end;
    logic cnt_ok;

    assign sclk        = st_reg.sclk_s[1];
    assign select_n         = st_reg.csn_s[1];
    assign sclk_rise   = sclk & ~st_reg.sclk_d;
    assign sclk_fall   = ~sclk & st_reg.sclk_d;
    assign frame_start = ~select_n & st_reg.csn_d;
    assign frame_end   = select_n & ~st_reg.csn_d;
    assign cnt_ok      = (st_reg.cnt == CNT_ZERO) || (st_reg.cnt == CNT_FULL);

    always_comb
    begin
        st_next        = st_reg;
        st_next.sclk_s = {st_reg.sclk_s[0], i_sclk};
        st_next.csn_s  = {st_reg.csn_s[0], i_select_n};
        st_next.sdi_s  = {st_reg.sdi_s[0], i_sdi};
        st_next.sclk_d = sclk;
        st_next.csn_d  = select_n;
        st_next.valid  = 1'b0;
        if (i_restart)
        begin
            st_next.rst_seen = 1'b1;
        end
        if (frame_start)
        begin
            st_next.cnt = CNT_ZERO;
            st_next.oe  = 1'b1;
            // The error from the previous frame leads; the old status byte follows.
            st_next.sdo = st_reg.err | i_restart;
            st_next.tx  = {st_reg.err | i_restart, {(FRAME_BITS-1){1'b0}}};
            st_next.err = 1'b0;
            st_next.rst_seen = i_restart;
        end
        else if (!select_n)
        begin
            if (sclk_fall)
            begin
                // Shift in LSB first; input never feeds the output path.
                st_next.rx = {st_reg.sdi_s[1], st_reg.rx[FRAME_BITS-1:1]};
                if (st_reg.cnt != CNT_OVER)
                begin
                    st_next.cnt = st_reg.cnt + CNT_STEP;
                end
                // The seventh address bit is still on the synchronised input here.
                if (st_reg.cnt == CNT_ADDR)
                begin
                    st_next.rsp_addr = {st_reg.sdi_s[1], st_reg.rx[FRAME_BITS-1 -: ADDR_W-1]};
                end
            end
            if (sclk_rise)
            begin
                if (st_reg.cnt == CNT_RSP)
                begin
                    // Response byte is the register's pre-write contents.
                    st_next.sdo = i_rsp_data[0];
                    st_next.tx  = {{(FRAME_BITS-DATA_W){1'b0}}, i_rsp_data};
                end
                else
                begin
                    st_next.sdo = st_reg.tx[1];
                    st_next.tx  = {1'b0, st_reg.tx[FRAME_BITS-1:1]};
                end
                if (i_restart)
                begin
                    st_next.sdo = 1'b1;
                end
            end
        end
        if (frame_end)
        begin
            st_next.oe  = 1'b0;
            st_next.sdo = 1'b0;
            // Clock still high when select_n rises also counts as a framing fault.
            if (!cnt_ok || sclk || st_reg.rst_seen || i_restart)
            begin
                st_next.err = 1'b1;
            end
            if (cnt_ok && (st_reg.cnt == CNT_FULL) && !sclk && !st_reg.rst_seen && !i_restart)
            begin
                st_next.valid = 1'b1;
                st_next.addr  = st_reg.rx[ADDR_LSB +: ADDR_W];
                st_next.wr    = st_reg.rx[WR_BIT];
                st_next.data  = st_reg.rx[DATA_LSB +: DATA_W];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_reg        <= '0;
            st_reg.sclk_s <= 2'h0;
            st_reg.csn_s  <= 2'h3;
            st_reg.csn_d  <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_sdo       = st_reg.sdo;
    assign o_sdo_oe    = st_reg.oe;
    assign o_rsp_addr  = st_reg.rsp_addr;
    assign o_cmd_valid = st_reg.valid;
    assign o_cmd_addr  = st_reg.addr;
    assign o_cmd_write = st_reg.wr;
    assign o_cmd_data  = st_reg.data;
endmodule

// ### sim/sixteen_bit_spi_target_port_tb.sv
// Self-checking bench for the sixteen-bit serial target port.
`timescale 1ns/100ps
module sixteen_bit_spi_target_port_tb;
    logic        clk = 0, nrst = 0, restart = 0, sclk, sel_n, sdi, sdo, oe, valid, wr, got;
    logic [7:0]  rsp = 8'h00, cdata;
    logic [6:0]  raddr, caddr;
    logic [15:0] r, w, cap;
    int          fail_count = 0, checks_done = 0, seed = 32'hfd3b4dbf;
    int          ns[12] = '{16, 16, 15, 16, 0, 16, 17, 16, 1, 16, 16, 16};
    bit          err = 0, rst, sel;
    always #5 clk = ~clk;
    spi_target_port dut_u (.i_sys_clk(clk), .i_nrst(nrst), .i_sclk(sclk), .i_select_n(sel_n),
        .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(oe), .i_restart(restart), .i_rsp_data(rsp),
        .o_rsp_addr(raddr), .o_cmd_valid(valid), .o_cmd_addr(caddr), .o_cmd_write(wr),
        .o_cmd_data(cdata));
    spi_host_model host_u (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(oe), .o_sclk(sclk),
        .o_select_n(sel_n), .o_sdi(sdi));
    always @(posedge clk) if (valid) {got, cap} <= {1'b1, cdata, wr, caddr};
    function automatic logic [15:0] reply(logic [7:0] d, bit e);
        return {d, 7'h00, e};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        test_done();
    end
    initial
    begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        for (int k = 0; k < 12; k++)
        begin
            w = $random(seed);
            rsp = $random(seed);
            w = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : w;
            rst = (k == 10);
            sel = (k != 9);
            got = 1'b0;
            fork
                host_u.xfer(w, ns[k], sel, r);
                if (rst)
                begin
                    repeat (30) @(negedge clk);
                    restart = 1'b1;
                end
            join
            if (sel) chk({15'h0000, r[0]}, {15'h0000, err});
            if (sel && ns[k] == 16 && !rst) chk(r, reply(rsp, err));
            chk({15'h0000, got}, {15'h0000, sel && ns[k] == 16 && !rst});
            if (got === 1'b1) chk(cap, w);
            if (sel && ns[k] >= 7) chk({9'h000, raddr}, {9'h000, w[6:0]});
            restart = 1'b0;
            if (sel) err = rst || (ns[k] != 0 && ns[k] != 16);
        end
        test_done();
    end
endmodule

// ### sim/spi_host_model.sv
// Host controller model that clocks one frame at a time.
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic i_clk,      // System clock.
    input  wire logic i_sdo,      // Data out of the port.
    input  wire logic i_sdo_oe,   // Port drives data out.
    output logic      o_sclk,     // Serial clock.
    output logic      o_select_n, // Frame select.
    output logic      o_sdi       // Serial data in.
);
    initial {o_sclk, o_select_n, o_sdi} = 3'h2;
    // Serial clock is low at both select edges.
    task automatic xfer(input logic [15:0] w, input int n, input bit sel, output logic [15:0] r);
        r = 16'h0000;
        o_select_n = !sel;
        repeat (8) @(negedge i_clk);
        for (int i = 0; i < n; i++)
        begin
            if (i < 16) r[i] = i_sdo_oe ? i_sdo : 1'bz;
            o_sdi = w[i % 16];
            o_sclk = 1'b1;
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b0;
            repeat (4) @(negedge i_clk);
        end
        o_select_n = 1'b1;
        // A released line must not keep showing the last bit.
        o_sdi = !o_sdi;
        repeat (8) @(negedge i_clk);
    endtask
endmodule

// ### sim/spi_target_properties.sv
// Port timing assertions for the serial target port.
`timescale 1ns/100ps
module spi_target_properties (
    input wire logic i_sys_clk,  // Clock.
    input wire logic i_nrst,     // Reset.
    input wire logic i_sclk,     // Serial clock.
    input wire logic i_select_n, // Frame select.
    input wire logic i_restart,  // Restart mode.
    input wire logic o_sdo,      // Data out.
    input wire logic o_sdo_oe,   // Drive enable.
    input wire logic o_cmd_valid // Command pulse.
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    AST_OE_ON: assert property ($fell(i_select_n) |-> ##[1:6] o_sdo_oe) else $error("oe");
    AST_OE_HOLD: assert property (!i_select_n [*6] |-> o_sdo_oe) else $error("oe hold");
    AST_OE_OFF: assert property (i_select_n [*6] |-> !o_sdo_oe) else $error("oe off");
    AST_CMD_LATE: assert property (o_cmd_valid |-> i_select_n && $past(i_select_n, 2)) else $error("early");
    AST_CMD_PULSE: assert property (o_cmd_valid |=> !o_cmd_valid) else $error("pulse");
    AST_IDLE_QUIET: assert property (i_select_n [*8] |-> !o_cmd_valid) else $error("idle");
    AST_SDO_STILL: assert property ((!i_sclk && o_sdo_oe) [*6] |-> $stable(o_sdo)) else $error("sdo");
    AST_RESTART_MUTE: assert property (i_restart [*8] |-> !o_cmd_valid) else $error("restart");
    COV_CMD: cover property (o_cmd_valid);
    COV_ERR: cover property (o_sdo_oe && o_sdo && !i_sclk);
    COV_RESTART: cover property (i_restart && !i_select_n);
endmodule
bind spi_target_port spi_target_properties chk_u (.*);
